// *** core/ufb_pkg.sv ***
// package: register map, fields, reset values and carriers
`default_nettype none
package ufb_pkg;

    // =====================================================================
    // register offsets on the 3-bit host address
    localparam logic [2:0] OFS_DIV_LO      = 3'h0;
    localparam logic [2:0] OFS_DIV_HI      = 3'h1;
    localparam logic [2:0] OFS_FIFO_CTRL   = 3'h2;
    localparam logic [2:0] OFS_DIV_FRAC    = 3'h2;
    localparam logic [2:0] OFS_LINE_CTRL   = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTRL  = 3'h4;
    localparam logic [2:0] OFS_LINE_STATUS = 3'h5;

    // =====================================================================
    // field positions
    localparam int FCR_FIFO_EN_BIT   = 0;
    localparam int FCR_BLOCK_BIT     = 3;
    localparam int LCR_DIV_ACCESS    = 7;
    localparam int MCR_PRESCALE_BIT  = 7;
    localparam int FRAC_LSB          = 0;
    localparam int FRAC_W            = 4;
    localparam int SAMP_LSB          = 4;
    localparam int LSR_RX_AVAIL_BIT  = 0;
    localparam int LSR_THR_EMPTY_BIT = 5;

    // =====================================================================
    // reset values
    localparam logic [7:0] DIV_LO_RST  = 8'h01;
    localparam logic [7:0] DIV_HI_RST  = 8'h00;
    localparam logic [7:0] DIV_FRAC_RST = 8'h00;
    localparam logic [7:0] FCR_RST     = 8'h00;
    localparam logic [7:0] LCR_RST     = 8'h00;
    localparam logic [7:0] MCR_RST     = 8'h00;
    localparam logic [7:0] FRAC_MASK   = 8'h3F;

    // =====================================================================
    // counts
    localparam int LVL_W            = 6;
    localparam int PRESCALE_DIV4    = 4;
    localparam int STRAP_SETTLE     = 4;
    localparam int BIT_PERIODS_16X  = 16;
    localparam int BIT_PERIODS_8X   = 8;
    localparam int BIT_PERIODS_4X   = 4;
    localparam int FRAC_STEPS       = 16;

    typedef enum logic [1:0] {
        SAMP_16X = 2'b00,
        SAMP_8X  = 2'b01,
        SAMP_4X  = 2'b10,
        SAMP_RSV = 2'b11
    } ufb_samp_t;

    // occupancy and trigger state from the fifo/holding logic
    typedef struct packed {
        logic [LVL_W-1:0] rx_level;
        logic [LVL_W-1:0] tx_level;
        logic             rx_above_trig;
        logic             rx_trig_reached;
        logic             rx_timeout;
        logic             tx_above_trig;
        logic             rx_hold_full;
        logic             tx_hold_full;
    } ufb_fifo_stat_t;

    // baud generator settings
    typedef struct packed {
        logic [15:0]      div_int;
        logic [FRAC_W-1:0] div_frac;
        ufb_samp_t        samp;
        logic             prescale4;
    } ufb_baud_cfg_t;

endpackage
`default_nettype wire

// *** core/ufb_sync.sv ***
// module: three-stage input synchroniser with agreement filter
`default_nettype none
module ufb_sync #(
    parameter int                 W   = 1,
    parameter logic [W-1:0]       RST = '0
) (
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // =====================================================================
    // stages
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // a change only counts once the last two stages agree
    assign out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    assign sync_out = out_reg;

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s1_reg  <= RST;
            s2_reg  <= RST;
            s3_reg  <= RST;
            out_reg <= RST;
        end
        else
        begin
            s1_reg  <= async_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

endmodule
`default_nettype wire

// *** core/ufb_baud.sv ***
// module: prescaler, fractional baud generator and bit timing
`default_nettype none
module ufb_baud (
    input  wire logic                   core_clk_in,
    input  wire logic                   sys_rst_in,
    input  wire ufb_pkg::ufb_baud_cfg_t cfg_in,
    output logic                        sample_tick_out,
    output logic                        bit_tick_out
);

    // =====================================================================
    // prescaler
    logic [1:0]  pre_reg;
    logic [1:0]  pre_next;
    wire         pre_tick = !cfg_in.prescale4 || (pre_reg == 2'(ufb_pkg::PRESCALE_DIV4 - 1));
    assign pre_next = pre_tick ? 2'h0 : pre_reg + 2'h1;

    // =====================================================================
    // fractional divider in sixteenths; zero integer part held at one
    logic [20:0] acc_reg;
    logic [20:0] acc_next;
    wire  [15:0] div_int_eff = (cfg_in.div_int == 16'h0000) ? 16'h0001 : cfg_in.div_int;
    wire  [20:0] div_16ths   = {1'b0, div_int_eff, cfg_in.div_frac};
    wire  [20:0] acc_add     = acc_reg + 21'(ufb_pkg::FRAC_STEPS);
    wire         samp_hit    = pre_tick && (acc_add >= div_16ths);
    // odd fractions spread remainder across periods; 8X bits jitter by 1/16 here
    assign acc_next = !pre_tick ? acc_reg : (samp_hit ? acc_add - div_16ths : acc_add);

    // =====================================================================
    // bit timing: 16, 8 or 4 sampling periods per bit
    logic [4:0]  samp_cnt_reg;
    logic [4:0]  samp_cnt_next;
    wire  [4:0]  bit_len = (cfg_in.samp == ufb_pkg::SAMP_8X) ? 5'(ufb_pkg::BIT_PERIODS_8X) :
                           (cfg_in.samp == ufb_pkg::SAMP_4X) ? 5'(ufb_pkg::BIT_PERIODS_4X) :
                           5'(ufb_pkg::BIT_PERIODS_16X);
    wire         bit_hit = samp_hit && (samp_cnt_reg >= bit_len - 5'h01);
    assign samp_cnt_next = !samp_hit ? samp_cnt_reg : (bit_hit ? 5'h00 : samp_cnt_reg + 5'h01);

    logic samp_tick_reg;
    logic bit_tick_reg;
    assign sample_tick_out = samp_tick_reg;
    assign bit_tick_out    = bit_tick_reg;

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pre_reg       <= 2'h0;
            acc_reg       <= 21'h000000;
            samp_cnt_reg  <= 5'h00;
            samp_tick_reg <= 1'b0;
            bit_tick_reg  <= 1'b0;
        end
        else
        begin
            pre_reg       <= pre_next;
            acc_reg       <= acc_next;
            samp_cnt_reg  <= samp_cnt_next;
            samp_tick_reg <= samp_hit;
            bit_tick_reg  <= bit_hit;
        end
    end

endmodule
`default_nettype wire

// *** core/ufb_channel.sv ***
// module: one channel's ready/interrupt pins, divisor registers and host port
`default_nettype none
// Behaviour
// - no fifo: tx int low while holding full
// - block mode: tx int low above trigger
// - no fifo: rx int high with byte held
// - fifo: rx int follows above-trigger state
// - fifo-control bit selects block transfer mode
// - no fifo: ready pins follow holding registers
// - single mode: rx ready nonempty, tx empty
// - block rx ready: fall trigger/timeout, rise empty
// - block tx ready low unless fifo full
// - oscillator clocks baud, sync and registers; reads need it
// - modem-control bit seven divides input by four
// - divisor one to 65535 15/16 in sixteenths
// - reset divisor is exactly one
// - integer divisor from low and high bytes
// - low four fraction bits give n/16
// - fraction bits 5:4 select 16X/8X/4X
// - sampling clock shared; 8X/4X raise rate
// - 8X odd fraction allows 1/16 jitter
// - strap pin presets prescaler, software overrides
// - bit lasts 16, 8 or 4 samples
module ufb_channel #(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic                    core_clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic                    bus_cs_n_in,
    input  wire logic                    bus_rd_n_in,
    input  wire logic                    bus_wr_n_in,
    input  wire logic [2:0]              bus_addr_in,
    input  wire logic [7:0]              bus_data_in,
    output logic      [7:0]              bus_data_out,
    output logic                         bus_data_oe_out,
    input  wire logic                    prescale_select_pin_in,
    input  wire ufb_pkg::ufb_fifo_stat_t fifo_stat_in,
    output logic                         int_tx_out,
    output logic                         int_rx_out,
    output logic                         int_out,
    output logic                         rx_ready_n_out,
    output logic                         tx_ready_n_out,
    output logic                         fifo_enable_out,
    output logic                         block_mode_out,
    output logic                         sample_tick_out,
    output logic                         bit_tick_out
);

    // =====================================================================
    // host strobe synchronisation
    logic [13:0] bus_sync;
    ufb_sync #(
        .W   (14),
        .RST (14'h3800)
    ) u_bus_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .async_in    ({bus_cs_n_in, bus_rd_n_in, bus_wr_n_in, bus_addr_in, bus_data_in}),
        .sync_out    (bus_sync)
    );

    logic strap_sync;
    ufb_sync #(
        .W   (1),
        .RST (1'b0)
    ) u_strap_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .async_in    (prescale_select_pin_in),
        .sync_out    (strap_sync)
    );

    wire       s_cs_n = bus_sync[13];
    wire       s_wr_n = bus_sync[11];
    wire [2:0] s_addr = bus_sync[10:8];
    wire [7:0] s_data = bus_sync[7:0];

    logic wr_act_reg;
    wire  wr_act  = !s_cs_n && !s_wr_n;
    // commit on the strobe's trailing edge, address and data settled
    wire  wr_done = wr_act_reg && !wr_act;

    // =====================================================================
    // registers
    logic [7:0] div_lo_reg;
    logic [7:0] div_hi_reg;
    logic [7:0] div_frac_reg;
    logic [7:0] fcr_reg;
    logic [7:0] lcr_reg;
    logic [7:0] mcr_reg;
    logic [2:0] wr_addr_reg;
    logic [7:0] wr_data_reg;

    wire div_access = lcr_reg[ufb_pkg::LCR_DIV_ACCESS];

    wire wr_div_lo  = wr_done && div_access && (wr_addr_reg == ufb_pkg::OFS_DIV_LO);
    wire wr_div_hi  = wr_done && div_access && (wr_addr_reg == ufb_pkg::OFS_DIV_HI);
    wire wr_div_frc = wr_done && div_access && (wr_addr_reg == ufb_pkg::OFS_DIV_FRAC);
    wire wr_fcr     = wr_done && !div_access && (wr_addr_reg == ufb_pkg::OFS_FIFO_CTRL);
    wire wr_lcr     = wr_done && (wr_addr_reg == ufb_pkg::OFS_LINE_CTRL);
    wire wr_mcr     = wr_done && (wr_addr_reg == ufb_pkg::OFS_MODEM_CTRL);

    wire [7:0] div_lo_next   = wr_div_lo ? wr_data_reg : div_lo_reg;
    wire [7:0] div_hi_next   = wr_div_hi ? wr_data_reg : div_hi_reg;
    wire [7:0] div_frac_next = wr_div_frc ? (wr_data_reg & ufb_pkg::FRAC_MASK) : div_frac_reg;
    wire [7:0] fcr_next      = wr_fcr ? wr_data_reg : fcr_reg;
    wire [7:0] lcr_next      = wr_lcr ? wr_data_reg : lcr_reg;

    // =====================================================================
    // prescaler strap: caught once after reset release, later writes win
    logic [2:0] strap_cnt_reg;
    logic       strap_done_reg;
    wire        strap_load = !strap_done_reg && (strap_cnt_reg == 3'(ufb_pkg::STRAP_SETTLE));
    wire [2:0]  strap_cnt_next = strap_done_reg ? strap_cnt_reg : strap_cnt_reg + 3'h1;
    logic [7:0] mcr_next;
    always_comb
    begin
        mcr_next = mcr_reg;
        if (strap_load)
        begin
            mcr_next[ufb_pkg::MCR_PRESCALE_BIT] = strap_sync;
        end
        if (wr_mcr)
        begin
            mcr_next = wr_data_reg;
        end
    end

    // =====================================================================
    // mode decode
    wire fifo_en  = fcr_reg[ufb_pkg::FCR_FIFO_EN_BIT];
    wire blk_mode = fifo_en && fcr_reg[ufb_pkg::FCR_BLOCK_BIT];

    wire [ufb_pkg::LVL_W-1:0] depth_lvl = ufb_pkg::LVL_W'(FIFO_DEPTH);
    wire rx_empty = (fifo_stat_in.rx_level == '0);
    wire tx_empty = (fifo_stat_in.tx_level == '0);
    wire tx_full  = (fifo_stat_in.tx_level >= depth_lvl);

    // =====================================================================
    // interrupt levels
    logic int_tx_next;
    logic int_rx_next;
    always_comb
    begin
        if (!fifo_en)
        begin
            int_tx_next = !fifo_stat_in.tx_hold_full;
            int_rx_next = fifo_stat_in.rx_hold_full;
        end
        else
        begin
            // non-block tx level unspecified; tx fifo empty chosen
            int_tx_next = blk_mode ? !fifo_stat_in.tx_above_trig : tx_empty;
            int_rx_next = fifo_stat_in.rx_above_trig;
        end
    end

    // =====================================================================
    // ready pins
    logic rx_rdy_n_next;
    logic tx_rdy_n_next;
    always_comb
    begin
        if (!fifo_en)
        begin
            rx_rdy_n_next = !fifo_stat_in.rx_hold_full;
            tx_rdy_n_next = fifo_stat_in.tx_hold_full;
        end
        else if (!blk_mode)
        begin
            rx_rdy_n_next = rx_empty;
            tx_rdy_n_next = !tx_empty;
        end
        else
        begin
            // latched: trigger beats empty in one cycle
            rx_rdy_n_next = rx_ready_n_out;
            if (rx_empty)
            begin
                rx_rdy_n_next = 1'b1;
            end
            if (fifo_stat_in.rx_trig_reached || fifo_stat_in.rx_timeout)
            begin
                rx_rdy_n_next = 1'b0;
            end
            tx_rdy_n_next = tx_full;
        end
    end

    // =====================================================================
    // read mux; address is synchronised and read data registered,
    // so reads need oscillator edges, as refreshes do
    logic [7:0] lsr_view;
    always_comb
    begin
        lsr_view = 8'h00;
        lsr_view[ufb_pkg::LSR_RX_AVAIL_BIT]  = fifo_en ? !rx_empty : fifo_stat_in.rx_hold_full;
        lsr_view[ufb_pkg::LSR_THR_EMPTY_BIT] = fifo_en ? tx_empty : !fifo_stat_in.tx_hold_full;
    end

    logic [7:0] rd_next;
    always_comb
    begin
        case (s_addr)
            ufb_pkg::OFS_DIV_LO:      rd_next = div_access ? div_lo_reg : 8'h00;
            ufb_pkg::OFS_DIV_HI:      rd_next = div_access ? div_hi_reg : 8'h00;
            ufb_pkg::OFS_DIV_FRAC:    rd_next = div_access ? div_frac_reg : fcr_reg;
            ufb_pkg::OFS_LINE_CTRL:   rd_next = lcr_reg;
            ufb_pkg::OFS_MODEM_CTRL:  rd_next = mcr_reg;
            ufb_pkg::OFS_LINE_STATUS: rd_next = lsr_view;
            default:                  rd_next = 8'h00;
        endcase
    end

    logic [7:0] rd_data_reg;
    assign bus_data_out    = rd_data_reg;
    assign bus_data_oe_out = !bus_cs_n_in && !bus_rd_n_in;

    // =====================================================================
    // baud generator
    ufb_pkg::ufb_baud_cfg_t baud_cfg;
    assign baud_cfg.div_int   = {div_hi_reg, div_lo_reg};
    assign baud_cfg.div_frac  = div_frac_reg[ufb_pkg::FRAC_LSB +: ufb_pkg::FRAC_W];
    assign baud_cfg.samp      = ufb_pkg::ufb_samp_t'(div_frac_reg[ufb_pkg::SAMP_LSB +: 2]);
    assign baud_cfg.prescale4 = mcr_reg[ufb_pkg::MCR_PRESCALE_BIT];

    ufb_baud u_baud (
        .core_clk_in     (core_clk_in),
        .sys_rst_in      (sys_rst_in),
        .cfg_in          (baud_cfg),
        .sample_tick_out (sample_tick_out),
        .bit_tick_out    (bit_tick_out)
    );

    // =====================================================================
    // output and state flops
    logic int_tx_reg;
    logic int_rx_reg;
    logic rx_rdy_n_reg;
    logic tx_rdy_n_reg;

    assign int_tx_out      = int_tx_reg;
    assign int_rx_out      = int_rx_reg;
    assign int_out         = int_tx_reg || int_rx_reg;
    assign rx_ready_n_out  = rx_rdy_n_reg;
    assign tx_ready_n_out  = tx_rdy_n_reg;
    assign fifo_enable_out = fifo_en;
    assign block_mode_out  = blk_mode;

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            div_lo_reg     <= ufb_pkg::DIV_LO_RST;
            div_hi_reg     <= ufb_pkg::DIV_HI_RST;
            div_frac_reg   <= ufb_pkg::DIV_FRAC_RST;
            fcr_reg        <= ufb_pkg::FCR_RST;
            lcr_reg        <= ufb_pkg::LCR_RST;
            mcr_reg        <= ufb_pkg::MCR_RST;
            strap_cnt_reg  <= 3'h0;
            strap_done_reg <= 1'b0;
            wr_act_reg     <= 1'b0;
            wr_addr_reg    <= 3'h0;
            wr_data_reg    <= 8'h00;
            rd_data_reg    <= 8'h00;
            int_tx_reg     <= 1'b1;
            int_rx_reg     <= 1'b0;
            rx_rdy_n_reg   <= 1'b1;
            tx_rdy_n_reg   <= 1'b0;
        end
        else
        begin
            div_lo_reg     <= div_lo_next;
            div_hi_reg     <= div_hi_next;
            div_frac_reg   <= div_frac_next;
            fcr_reg        <= fcr_next;
            lcr_reg        <= lcr_next;
            mcr_reg        <= mcr_next;
            strap_cnt_reg  <= strap_cnt_next;
            strap_done_reg <= strap_done_reg || strap_load;
            wr_act_reg     <= wr_act;
            wr_addr_reg    <= wr_act ? s_addr : wr_addr_reg;
            wr_data_reg    <= wr_act ? s_data : wr_data_reg;
            rd_data_reg    <= rd_next;
            int_tx_reg     <= int_tx_next;
            int_rx_reg     <= int_rx_next;
            rx_rdy_n_reg   <= rx_rdy_n_next;
            tx_rdy_n_reg   <= tx_rdy_n_next;
        end
    end

endmodule
`default_nettype wire

// *** test/ufb_channel_properties.sv ***
// checker: pin and read-enable relations of one channel
`default_nettype none
module ufb_channel_properties #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic                    core_clk_in,
    input wire logic                    sys_rst_in,
    input wire logic                    bus_cs_n_in,
    input wire logic                    bus_rd_n_in,
    input wire logic                    bus_data_oe_out,
    input wire ufb_pkg::ufb_fifo_stat_t fifo_stat_in,
    input wire logic                    int_tx_out,
    input wire logic                    int_rx_out,
    input wire logic                    rx_ready_n_out,
    input wire logic                    tx_ready_n_out,
    input wire logic                    fifo_enable_out,
    input wire logic                    block_mode_out,
    input wire logic                    sample_tick_out,
    input wire logic                    bit_tick_out
);
    // =====================================================================
    // a mode must stand two edges before pins are judged
    logic       was_run_reg;
    logic       was_fe_reg;
    logic       was_bk_reg;
    wire  logic off_w = was_run_reg & !fifo_enable_out & !was_fe_reg;
    wire  logic fe_w  = was_run_reg & fifo_enable_out & was_fe_reg;
    wire  logic sgl_w = fe_w & !block_mode_out & !was_bk_reg;
    wire  logic blk_w = was_run_reg & block_mode_out & was_bk_reg;

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            {was_run_reg, was_fe_reg, was_bk_reg} <= 3'h0;
        else
            {was_run_reg, was_fe_reg, was_bk_reg} <= {1'b1, fifo_enable_out, block_mode_out};
    end

    // =====================================================================
    // assertions
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_off_tx_int: assert property (
        off_w |-> int_tx_out == !$past(fifo_stat_in.tx_hold_full)) else $error("tx int wrong, fifo off");
    chk_off_rx_int: assert property (
        off_w |-> int_rx_out == $past(fifo_stat_in.rx_hold_full)) else $error("rx int wrong, fifo off");
    chk_off_ready: assert property (
        off_w |-> rx_ready_n_out == !$past(fifo_stat_in.rx_hold_full)
                  && tx_ready_n_out == $past(fifo_stat_in.tx_hold_full)) else $error("ready wrong, fifo off");
    chk_single_ready: assert property (
        sgl_w |-> rx_ready_n_out == ($past(fifo_stat_in.rx_level) == 6'h00)
                  && tx_ready_n_out == ($past(fifo_stat_in.tx_level) != 6'h00)) else $error("single ready wrong");
    chk_fifo_rx_int: assert property (
        fe_w |-> int_rx_out == $past(fifo_stat_in.rx_above_trig)) else $error("rx int wrong, fifo on");
    chk_block_tx_int: assert property (
        blk_w |-> int_tx_out == !$past(fifo_stat_in.tx_above_trig)) else $error("tx int wrong, block");
    chk_block_tx_ready: assert property (
        blk_w |-> tx_ready_n_out == ($past(fifo_stat_in.tx_level) >= FIFO_DEPTH)) else $error("tx ready wrong");
    chk_block_rx_fall: assert property (
        blk_w && (fifo_stat_in.rx_trig_reached || fifo_stat_in.rx_timeout) |=> !rx_ready_n_out)
        else $error("rx ready did not fall");
    chk_block_rx_rise: assert property (
        blk_w && fifo_stat_in.rx_level == 6'h00 && !fifo_stat_in.rx_trig_reached && !fifo_stat_in.rx_timeout
        |=> rx_ready_n_out) else $error("rx ready did not rise");
    chk_read_drive: assert property (
        bus_data_oe_out == (!bus_cs_n_in && !bus_rd_n_in)) else $error("read enable wrong");
    chk_bit_on_sample: assert property (
        bit_tick_out |-> sample_tick_out) else $error("bit tick off a sample tick");
endmodule
`default_nettype wire

// *** test/ufb_host_model.sv ***
// partner model: host processor on the asynchronous register bus
`default_nettype none
module ufb_host_model (
    input  wire logic       core_clk_in,
    input  wire logic [7:0] bus_data_in,
    output logic            bus_cs_n_out,
    output logic            bus_rd_n_out,
    output logic            bus_wr_n_out,
    output logic [2:0]      bus_addr_out,
    output logic [7:0]      bus_data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {bus_cs_n_out, bus_rd_n_out, bus_wr_n_out} = 3'h7;
        bus_addr_out = 3'h7;
        bus_data_out = 8'hA5;
    end

    // =====================================================================
    // one access; strobes stand 8 clocks each way for the 3-stage sync
    task automatic cycle(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk_in);
        bus_addr_out <= a;
        bus_data_out <= wr ? d : ~bus_data_out;
        bus_cs_n_out <= 1'b0;
        bus_rd_n_out <= wr;
        bus_wr_n_out <= !wr;
        repeat (8) @(posedge core_clk_in);
        q = bus_data_in;
        {bus_cs_n_out, bus_rd_n_out, bus_wr_n_out} <= 3'h7;
        repeat (8) @(posedge core_clk_in);
        // released data stops showing the last byte
        bus_data_out <= ~bus_data_out;
    endtask
endmodule
`default_nettype wire

// *** test/tb_ufb_channel.sv ***
// testbench: register access, ready/interrupt pins and baud tick rates
`default_nettype none
module tb_ufb_channel;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    core_clk_in = 1'b0;
    logic                    sys_rst_in = 1'b1;
    logic                    prescale_select_pin_in = 1'b1;
    ufb_pkg::ufb_fifo_stat_t fifo_stat_in = '0;
    logic                    bus_cs_n_in, bus_rd_n_in, bus_wr_n_in, bus_data_oe_out;
    logic [2:0]              bus_addr_in;
    logic [7:0]              bus_data_in, bus_data_out, got;
    logic                    int_tx_out, int_rx_out, int_out, rx_ready_n_out, tx_ready_n_out;
    logic                    fifo_enable_out, block_mode_out, sample_tick_out, bit_tick_out;
    logic [5:0]              tl [4] = '{6'h00, 6'h01, 6'h1F, 6'h20};
    logic [7:0]              modes [4] = '{8'h00, 8'h08, 8'h01, 8'h09};
    int                      fails = 0, check_count = 0, ns, nb;

    ufb_channel #(.FIFO_DEPTH(32)) u_ufb_channel (
        .core_clk_in, .sys_rst_in, .bus_cs_n_in, .bus_rd_n_in, .bus_wr_n_in, .bus_addr_in, .bus_data_in,
        .bus_data_out, .bus_data_oe_out, .prescale_select_pin_in, .fifo_stat_in, .int_tx_out, .int_rx_out,
        .int_out, .rx_ready_n_out, .tx_ready_n_out, .fifo_enable_out, .block_mode_out, .sample_tick_out,
        .bit_tick_out
    );
    ufb_host_model u_ufb_host_model (
        .core_clk_in, .bus_data_in(bus_data_out), .bus_cs_n_out(bus_cs_n_in), .bus_rd_n_out(bus_rd_n_in),
        .bus_wr_n_out(bus_wr_n_in), .bus_addr_out(bus_addr_in), .bus_data_out(bus_data_in)
    );

    always #5 core_clk_in = ~core_clk_in;

    // =====================================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_ufb_host_model.cycle(1'b1, a, d, got);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        u_ufb_host_model.cycle(1'b0, a, 8'h00, got);
        check(got, e);
    endtask
    // tick counts may slip by one: phase unknown
    task automatic near(input int s, e);
        check(8'((s >= e - 1 && s <= e + 1) ? e : s), 8'(e));
    endtask
    task automatic ticks(input int n);
        ns = 0;
        nb = 0;
        repeat (n)
        begin
            @(posedge core_clk_in);
            ns += sample_tick_out;
            nb += bit_tick_out;
        end
    endtask
    task automatic stim(input logic [5:0] rl, tv, fl);
        @(posedge core_clk_in);
        fifo_stat_in <= {rl, tv, fl};
        repeat (2) @(posedge core_clk_in);
    endtask
    function automatic logic [4:0] pins(input logic fe, bk, lat);
        ufb_pkg::ufb_fifo_stat_t f = fifo_stat_in;
        logic [3:0]              p;
        if (!fe)
            p = {!f.tx_hold_full, f.rx_hold_full, !f.rx_hold_full, f.tx_hold_full};
        else if (!bk)
            p = {f.tx_level == 6'h00, f.rx_above_trig, f.rx_level == 6'h00, f.tx_level != 6'h00};
        else
            p = {!f.tx_above_trig, f.rx_above_trig, lat, f.tx_level >= 6'h20};
        return {p[3] | p[2], p};
    endfunction

    // =====================================================================
    // tests
    initial
    begin
        repeat (20) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        rd(3'h4, 8'h80);
        ticks(64);
        check(8'(ns), 8'h10);
        wr(3'h3, 8'h80);
        rd(3'h0, 8'h01);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h6, 8'h00);
        wr(3'h4, 8'h00);
        ticks(64);
        check(8'(ns), 8'h40);
        check(8'(nb), 8'h04);
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'h3F);
        for (int m = 0; m < 3; m++)
        begin
            wr(3'h2, 8'(m << 4));
            ticks(128);
            near(nb, 8 << m);
        end
        wr(3'h0, 8'h03);
        wr(3'h2, 8'h08);
        ticks(560);
        near(ns, 160);
        wr(3'h1, 8'h01);
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        ticks(1024);
        near(ns, 4);
        wr(3'h3, 8'h00);
        foreach (modes[k])
        begin
            wr(3'h2, modes[k]);
            check({fifo_enable_out, block_mode_out}, {modes[k][0], modes[k][0] & modes[k][3]});
            for (int i = 0; i < 4; i++)
            begin
                stim(6'(i), tl[i], {i[0], i[0], 1'b0, i[1], i[0], i[1]});
                check({int_out, int_tx_out, int_rx_out, rx_ready_n_out, tx_ready_n_out},
                      pins(modes[k][0], modes[k][0] & modes[k][3], i == 0));
            end
        end
        // block mode: timeout drop, hold, rise on empty
        for (int i = 0; i < 4; i++)
        begin
            stim(6'((i % 3) != 0 ? 3 : 0), 6'h00, {2'b00, i == 1, 3'b000});
            check(8'(rx_ready_n_out), 8'((i % 3) == 0));
        end
        rd(3'h5, 8'h20);
        final_report();
    end

    initial
    begin
        #200000;
        fails++;
        final_report();
    end
endmodule

bind ufb_channel ufb_channel_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_ufb_channel_properties (
    .core_clk_in, .sys_rst_in, .bus_cs_n_in, .bus_rd_n_in, .bus_data_oe_out, .fifo_stat_in, .int_tx_out,
    .int_rx_out, .rx_ready_n_out, .tx_ready_n_out, .fifo_enable_out, .block_mode_out, .sample_tick_out,
    .bit_tick_out
);
`default_nettype wire
